// ==== branch_target_decoder.sv ====
// immediate branch decoder and executor with link and loop counter
`timescale 1ns/1ps
// Functional notes
// - relative jump target is instruction address plus sign-extended displacement times four.
// - absolute jump target is sign-extended displacement times four, no address added.
// - absolute and link flags select the four unconditional forms.
// - link flag set on unconditional jump loads the link register.
// - no branch changes the exception register or condition field zero.
// - relative conditional target adds sign-extended short displacement times four.
// - absolute conditional target is sign-extended short displacement times four.
// - absolute and link flags select four conditional forms; link writes link register.
// - tested condition is the condition_flags bit picked by cond_select.
// - older codes 0000y-0101y decrement counter and test counter plus condition.
// - older codes 001zy and 011zy test condition only, counter untouched.
// - older 1z00y and 1z01y test decremented counter; 1z1zz always branches.
// - in newer variant a set z bit makes the form invalid.
// - y hint never changes the outcome.
// - legacy variant accepts any z and y values.
// - later encoding counter codes match older ones; 1z1zz always branches.
// - later codes 001at and 011at test condition only.
// - a/t hint never changes the outcome; 01 is treated as no hint.
// - link value is the address of the next instruction.
module branch_target_decoder
    import branch_target_pkg::*;
#(
    parameter int unsigned ADDR_W = WORD_W
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // variant selection
    input  wire logic              strictForms,
    input  wire logic              laterEncoding,
    // instruction from fetch
    input  wire logic              instrValid,
    input  wire logic [31:0]       instrWord,
    input  wire logic [ADDR_W-1:0] instrAddr,
    input  wire logic [31:0]       conditionFlags,
    // loop counter load
    input  wire logic              counterLoad,
    input  wire logic [31:0]       counterLoadValue,
    // results to sequencing logic
    output logic                   branchDone,
    output logic                   redirect,
    output logic [ADDR_W-1:0]      targetAddr,
    output logic                   invalidForm,
    output logic                   linkWritten,
    output logic [ADDR_W-1:0]      linkReg,
    output logic [31:0]            loopCounter,
    output logic                   hintGiven,
    output logic                   hintTaken
);

    if (ADDR_W != WORD_W) begin : g_addr_w_check
        $error("branch_target_decoder: ADDR_W must be 32");
    end

    // ------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------
    logic [5:0]        opcode;
    logic [4:0]        options;
    logic [4:0]        condSelect;
    logic              absoluteFlag;
    logic              linkFlag;
    logic              isJump;
    logic              isCond;
    logic [31:0]       longOffset;
    logic [31:0]       shortOffset;

    assign opcode       = instrWord[OPC_HI:OPC_LO];
    assign options      = instrWord[OPTIONS_HI:OPTIONS_LO];
    assign condSelect   = instrWord[SELECT_HI:SELECT_LO];
    assign absoluteFlag = instrWord[ABS_BIT];
    assign linkFlag     = instrWord[LINK_BIT];
    assign isJump       = instrValid && (opcode == OPC_JUMP);
    assign isCond       = instrValid && (opcode == OPC_COND_JUMP);
    // displacement times four, sign extended to a full word
    assign longOffset   = {{6{instrWord[LONG_DISP_HI]}}, instrWord[LONG_DISP_HI:LONG_DISP_LO], 2'b00};
    assign shortOffset  = {{16{instrWord[SHORT_DISP_HI]}}, instrWord[SHORT_DISP_HI:SHORT_DISP_LO], 2'b00};

    // ------------------------------------------------------------
    // branch_options decode
    // ------------------------------------------------------------
    logic              noCond;
    logic              noDec;
    logic              condBit;
    logic              condOk;
    logic              ctrOk;
    logic [31:0]       loopCounter_q, loopCounter_d;
    logic [31:0]       ctrMinusOne;
    logic              zViolation;
    logic              hintGivenComb;
    logic              hintTakenComb;

    assign noCond      = options[OPT_NO_COND];
    assign noDec       = options[OPT_NO_DEC];
    assign condBit     = conditionFlags[5'd31 - condSelect];
    assign condOk      = noCond || (condBit == options[OPT_SENSE]);
    assign ctrMinusOne = loopCounter_q - 32'h0000_0001;
    assign ctrOk       = noDec || ((ctrMinusOne == 32'h0000_0000) == options[OPT_ZERO]);

    always_comb begin
        zViolation    = 1'b0;
        hintGivenComb = 1'b0;
        hintTakenComb = 1'b0;
        case ({noCond, noDec})
            2'b00: begin
                // counter and condition: newer z in b4, older y in b4
                zViolation    = laterEncoding & options[OPT_HINT];
                hintGivenComb = ~laterEncoding;
                hintTakenComb = ~laterEncoding & options[OPT_HINT];
            end
            2'b01: begin
                // condition only: older z in b3, later a/t in b3/b4
                zViolation    = ~laterEncoding & options[OPT_ZERO];
                hintGivenComb = laterEncoding ? options[OPT_ZERO] : 1'b1;
                hintTakenComb = options[OPT_HINT];
            end
            2'b10: begin
                // counter only: older z in b1, later a in b1 and t in b4
                zViolation    = ~laterEncoding & options[OPT_SENSE];
                hintGivenComb = laterEncoding ? options[OPT_SENSE] : 1'b1;
                hintTakenComb = options[OPT_HINT];
            end
            2'b11: begin
                zViolation    = options[OPT_SENSE] | options[OPT_ZERO] | options[OPT_HINT];
            end
            default: begin
                zViolation    = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // result registers
    // ------------------------------------------------------------
    logic              branchDone_q,  branchDone_d;
    logic              redirect_q,    redirect_d;
    logic [31:0]       targetAddr_q,  targetAddr_d;
    logic              invalidForm_q, invalidForm_d;
    logic              linkWritten_q, linkWritten_d;
    logic [31:0]       linkReg_q,     linkReg_d;
    logic              hintGiven_q,   hintGiven_d;
    logic              hintTaken_q,   hintTaken_d;
    logic              badForm;

    // strict variant only; legacy ignores z bits entirely
    assign badForm = isCond && strictForms && zViolation;

    // condition flags and exception register are never driven from here
    always_comb begin
        branchDone_d  = isJump || (isCond && !badForm);
        invalidForm_d = badForm;
        redirect_d    = 1'b0;
        targetAddr_d  = targetAddr_q;
        linkWritten_d = 1'b0;
        linkReg_d     = linkReg_q;
        loopCounter_d = counterLoad ? counterLoadValue : loopCounter_q;
        hintGiven_d   = 1'b0;
        hintTaken_d   = 1'b0;
        if (isJump) begin
            redirect_d   = 1'b1;
            targetAddr_d = absoluteFlag ? longOffset : (instrAddr + longOffset);
        end else if (isCond && !badForm) begin
            // hints are reported but do not feed the outcome
            redirect_d   = condOk && ctrOk;
            targetAddr_d = absoluteFlag ? shortOffset : (instrAddr + shortOffset);
            hintGiven_d  = hintGivenComb;
            hintTaken_d  = hintTakenComb;
            // branch decrement wins over a same-cycle load
            if (!noDec) begin
                loopCounter_d = ctrMinusOne;
            end
        end
        if ((isJump || (isCond && !badForm)) && linkFlag) begin
            linkWritten_d = 1'b1;
            linkReg_d     = instrAddr + INSTR_BYTES;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            branchDone_q  <= 1'b0;
            redirect_q    <= 1'b0;
            targetAddr_q  <= RST_WORD;
            invalidForm_q <= 1'b0;
            linkWritten_q <= 1'b0;
            linkReg_q     <= RST_WORD;
            loopCounter_q <= RST_WORD;
            hintGiven_q   <= 1'b0;
            hintTaken_q   <= 1'b0;
        end else begin
            branchDone_q  <= branchDone_d;
            redirect_q    <= redirect_d;
            targetAddr_q  <= targetAddr_d;
            invalidForm_q <= invalidForm_d;
            linkWritten_q <= linkWritten_d;
            linkReg_q     <= linkReg_d;
            loopCounter_q <= loopCounter_d;
            hintGiven_q   <= hintGiven_d;
            hintTaken_q   <= hintTaken_d;
        end
    end

    assign branchDone  = branchDone_q;
    assign redirect    = redirect_q;
    assign targetAddr  = targetAddr_q;
    assign invalidForm = invalidForm_q;
    assign linkWritten = linkWritten_q;
    assign linkReg     = linkReg_q;
    assign loopCounter = loopCounter_q;
    assign hintGiven   = hintGiven_q;
    assign hintTaken   = hintTaken_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_jump_taken;
        @(posedge clk) disable iff (srst)
        isJump |=> redirect_q && branchDone_q && !invalidForm_q;
    endproperty
    a_jump_taken: assert property (p_jump_taken) else $error("unconditional jump not taken");

    property p_jump_rel;
        @(posedge clk) disable iff (srst)
        (isJump && !absoluteFlag) |=>
            targetAddr_q == $past(instrAddr) + {{6{$past(instrWord[25])}}, $past(instrWord[25:2]), 2'b00};
    endproperty
    a_jump_rel: assert property (p_jump_rel) else $error("relative jump target wrong");

    property p_jump_abs;
        @(posedge clk) disable iff (srst)
        (isJump && absoluteFlag) |=> targetAddr_q == {{6{$past(instrWord[25])}}, $past(instrWord[25:2]), 2'b00};
    endproperty
    a_jump_abs: assert property (p_jump_abs) else $error("absolute jump target wrong");

    property p_cond_rel;
        @(posedge clk) disable iff (srst)
        (isCond && !badForm && !absoluteFlag) |=>
            targetAddr_q == $past(instrAddr) + {{16{$past(instrWord[15])}}, $past(instrWord[15:2]), 2'b00};
    endproperty
    a_cond_rel: assert property (p_cond_rel) else $error("relative conditional target wrong");

    property p_cond_abs;
        @(posedge clk) disable iff (srst)
        (isCond && !badForm && absoluteFlag) |=> targetAddr_q == {{16{$past(instrWord[15])}}, $past(instrWord[15:2]), 2'b00};
    endproperty
    a_cond_abs: assert property (p_cond_abs) else $error("absolute conditional target wrong");

    property p_link_value;
        @(posedge clk) disable iff (srst)
        ((isJump || (isCond && !badForm)) && linkFlag) |=> linkWritten_q && linkReg_q == $past(instrAddr) + 32'h4;
    endproperty
    a_link_value: assert property (p_link_value) else $error("link register not next address");

    property p_link_hold;
        @(posedge clk) disable iff (srst)
        !(instrValid && linkFlag) |=> $stable(linkReg_q) && !linkWritten_q;
    endproperty
    a_link_hold: assert property (p_link_hold) else $error("link register changed without link");

    property p_ctr_dec;
        @(posedge clk) disable iff (srst)
        (isCond && !badForm && !noDec) |=> loopCounter_q == $past(loopCounter_q) - 32'h1;
    endproperty
    a_ctr_dec: assert property (p_ctr_dec) else $error("counter not decremented");

    property p_ctr_keep;
        @(posedge clk) disable iff (srst)
        (isCond && noDec && !counterLoad) |=> $stable(loopCounter_q);
    endproperty
    a_ctr_keep: assert property (p_ctr_keep) else $error("counter changed on condition-only branch");

    property p_always;
        @(posedge clk) disable iff (srst)
        (isCond && !badForm && noCond && noDec) |=> redirect_q;
    endproperty
    a_always: assert property (p_always) else $error("branch-always not taken");

    property p_cond_false;
        @(posedge clk) disable iff (srst)
        (isCond && !badForm && !noCond && (condBit != options[OPT_SENSE])) |=> branchDone_q && !redirect_q;
    endproperty
    a_cond_false: assert property (p_cond_false) else $error("branch taken on failed condition");

    property p_invalid;
        @(posedge clk) disable iff (srst)
        (isCond && strictForms && zViolation) |=> invalidForm_q && !redirect_q && !branchDone_q;
    endproperty
    a_invalid: assert property (p_invalid) else $error("set z bit not flagged invalid");

    // back-to-back bad forms are legal, so the pulse is checked per instruction
    property p_invalid_pulse;
        @(posedge clk) disable iff (srst)
        !(isCond && strictForms && zViolation) |=> !invalidForm_q;
    endproperty
    a_invalid_pulse: assert property (p_invalid_pulse) else $error("invalid flag without a bad form");

    property p_legacy;
        @(posedge clk) disable iff (srst)
        !strictForms |=> !invalidForm_q;
    endproperty
    a_legacy: assert property (p_legacy) else $error("legacy variant flagged invalid");

endmodule : branch_target_decoder

// ==== branch_target_pkg.sv ====
// constants for the immediate branch decoder
package branch_target_pkg;

    // ------------------------------------------------------------
    // primary opcodes and widths
    // ------------------------------------------------------------
    localparam int unsigned   WORD_W        = 32;
    localparam logic [5:0]    OPC_JUMP      = 6'h12;
    localparam logic [5:0]    OPC_COND_JUMP = 6'h10;
    localparam logic [31:0]   INSTR_BYTES   = 32'h0000_0004;

    // ------------------------------------------------------------
    // instruction field positions (bit 0 of the word is the lsb)
    // ------------------------------------------------------------
    localparam int unsigned   OPC_HI        = 31;
    localparam int unsigned   OPC_LO        = 26;
    localparam int unsigned   LONG_DISP_HI  = 25;
    localparam int unsigned   LONG_DISP_LO  = 2;
    localparam int unsigned   OPTIONS_HI    = 25;
    localparam int unsigned   OPTIONS_LO    = 21;
    localparam int unsigned   SELECT_HI     = 20;
    localparam int unsigned   SELECT_LO     = 16;
    localparam int unsigned   SHORT_DISP_HI = 15;
    localparam int unsigned   SHORT_DISP_LO = 2;
    localparam int unsigned   ABS_BIT       = 1;
    localparam int unsigned   LINK_BIT      = 0;

    // ------------------------------------------------------------
    // branch_options bits: b0 is the field msb
    // ------------------------------------------------------------
    localparam int unsigned   OPT_NO_COND   = 4;   // b0
    localparam int unsigned   OPT_SENSE     = 3;   // b1
    localparam int unsigned   OPT_NO_DEC    = 2;   // b2
    localparam int unsigned   OPT_ZERO      = 1;   // b3
    localparam int unsigned   OPT_HINT      = 0;   // b4

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0]   RST_WORD      = 32'h0000_0000;

endpackage : branch_target_pkg

// ==== fetch_model.sv ====
// fetch sequencer model that follows the decoder's redirects
`timescale 1ns/1ps
module fetch_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // instruction handed to the decoder
    input  wire logic        instrValid,
    input  wire logic [31:0] instrAddr,
    // decoder answer
    input  wire logic        redirect,
    input  wire logic [31:0] targetAddr,
    // address the sequencer fetches next
    output logic [31:0]      nextFetch
);
    logic [31:0] nextFetch_q;
    logic [31:0] nextFetch_d;

    // ------------------------------------------------------------
    // next fetch address
    // ------------------------------------------------------------
    // a late redirect overrides the sequential guess made a cycle earlier
    always_comb begin
        nextFetch_d = instrValid ? instrAddr + 32'h0000_0004 : nextFetch_q;
        if (redirect) begin
            nextFetch_d = targetAddr;
        end
    end

    always_ff @(posedge clk) begin
        nextFetch_q <= srst ? 32'h0000_0000 : nextFetch_d;
    end

    assign nextFetch = nextFetch_q;
endmodule : fetch_model

// ==== tb.sv ====
// self-checking bench for the immediate branch decoder
`timescale 1ns/1ps
module tb import branch_target_pkg::*;;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic        clk              = 1'b0;
    logic        srst             = 1'b1;
    logic        strictForms      = 1'b0;
    logic        laterEncoding    = 1'b0;
    logic        instrValid       = 1'b0;
    logic [31:0] instrWord        = 32'h0000_0000;
    logic [31:0] instrAddr        = 32'h0000_0000;
    logic [31:0] conditionFlags   = 32'h0000_0000;
    logic        counterLoad      = 1'b0;
    logic [31:0] counterLoadValue = 32'h0000_0000;
    logic        branchDone, redirect, invalidForm, linkWritten;
    logic        hintGiven, hintTaken;
    logic [31:0] targetAddr, linkReg, loopCounter, nextFetch, stat, expLink;
    int          errors     = 0;
    int          checkCount = 0;
    int          cycles     = 0;
    localparam logic [5:0] BAD_OPT [5] = '{6'h06, 6'h18, 6'h15, 6'h21, 6'h36};

    assign stat = {28'h0, branchDone, redirect, linkWritten, invalidForm};

    always #2.5 clk = ~clk;

    branch_target_decoder branch_target_decoder_inst (
        .clk(clk), .srst(srst), .strictForms(strictForms), .laterEncoding(laterEncoding),
        .instrValid(instrValid), .instrWord(instrWord), .instrAddr(instrAddr),
        .conditionFlags(conditionFlags), .counterLoad(counterLoad), .counterLoadValue(counterLoadValue),
        .branchDone(branchDone), .redirect(redirect), .targetAddr(targetAddr),
        .invalidForm(invalidForm), .linkWritten(linkWritten), .linkReg(linkReg),
        .loopCounter(loopCounter), .hintGiven(hintGiven), .hintTaken(hintTaken)
    );

    fetch_model fetch_model_inst (
        .clk(clk), .srst(srst), .instrValid(instrValid), .instrAddr(instrAddr),
        .redirect(redirect), .targetAddr(targetAddr), .nextFetch(nextFetch)
    );

    // ------------------------------------------------------------
    // helpers and scenarios
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        if (errors == 0 && checkCount > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // called at a falling edge; returns once the answer is registered
    task automatic exec(input logic [31:0] word, input logic [31:0] addr, input logic [31:0] flags);
        instrWord      = word;
        instrAddr      = addr;
        conditionFlags = flags;
        instrValid     = 1'b1;
        @(negedge clk);
        instrValid     = 1'b0;
    endtask : exec

    task automatic load_ctr(input logic [31:0] v);
        counterLoad      = 1'b1;
        counterLoadValue = v;
        @(negedge clk);
        counterLoad      = 1'b0;
        check(loopCounter, v);
    endtask : load_ctr

    task automatic t_uncond();
        logic [23:0] disp;
        logic [31:0] addr;
        logic [31:0] exp;
        for (int f = 0; f < 8; f++) begin
            disp = f[2] ? 24'h80_0000 : 24'h7F_FFFF;
            addr = 32'h1000_0000 + (32'(f) << 8);
            exp  = {{6{disp[23]}}, disp, 2'b00} + (f[1] ? 32'h0000_0000 : addr);
            expLink = f[0] ? addr + 32'h0000_0004 : expLink;
            exec({OPC_JUMP, disp, f[1], f[0]}, addr, 32'hFFFF_FFFF);
            check(stat, {28'h0, 2'b11, f[0], 1'b0});
            check(targetAddr, exp);
            check(linkReg, expLink);
            @(negedge clk);
            check(nextFetch, exp);
        end
        // neighbouring opcodes must be ignored
        for (int k = 0; k < 2; k++) begin
            exec({k ? 6'h11 : 6'h13, 26'h3FF_FFFF}, 32'h0000_0100, 32'h0000_0000);
            check(stat, 32'h0000_0000);
            check(linkReg, expLink);
            @(negedge clk);
        end
    endtask : t_uncond

    task automatic t_options(input logic later);
        logic [4:0]  opt;
        logic [4:0]  sel;
        logic [13:0] disp;
        logic [31:0] ctr, ctrNew, flags, addr, exp;
        logic        c, abs, link, taken;
        logic [1:0]  hint;
        laterEncoding = later;
        strictForms   = 1'b0;
        for (int i = 0; i < 128; i++) begin
            opt    = i[4:0];
            c      = i[5];
            sel    = opt ^ 5'h15;
            abs    = i[6] ^ i[0];
            link   = i[5] ^ i[1];
            disp   = {i[3], 13'h0ABC};
            addr   = 32'h0004_0000 + (32'(i) << 3);
            ctr    = {31'h0, i[6]};
            flags  = c ? 32'h8000_0000 >> sel : ~(32'h8000_0000 >> sel);
            ctrNew = opt[OPT_NO_DEC] ? ctr : ctr - 32'h0000_0001;
            taken  = (opt[OPT_NO_DEC] | ((ctrNew == 32'h0) == opt[OPT_ZERO]))
                   & (opt[OPT_NO_COND] | (c == opt[OPT_SENSE]));
            // {given, taken}: older y in b4, later a/t, nothing for branch-always
            hint   = (opt[OPT_NO_COND] & opt[OPT_NO_DEC]) ? 2'b00
                   : !later ? {1'b1, opt[OPT_HINT]}
                   : !(opt[OPT_NO_COND] | opt[OPT_NO_DEC]) ? 2'b00
                   : {opt[OPT_NO_COND] ? opt[OPT_SENSE] : opt[OPT_ZERO], opt[OPT_HINT]};
            exp    = {{16{disp[13]}}, disp, 2'b00} + (abs ? 32'h0000_0000 : addr);
            expLink = link ? addr + 32'h0000_0004 : expLink;
            load_ctr(ctr);
            exec({OPC_COND_JUMP, opt, sel, disp, abs, link}, addr, flags);
            check(stat, {28'h0, 1'b1, taken, link, 1'b0});
            check(loopCounter, ctrNew);
            check({30'h0, hintGiven, hintTaken}, {30'h0, hint});
            check(targetAddr, exp);
            check(linkReg, expLink);
            @(negedge clk);
            check(nextFetch, taken ? exp : addr + 32'h0000_0004);
        end
    endtask : t_options

    task automatic t_strict();
        strictForms = 1'b1;
        foreach (BAD_OPT[k]) begin
            laterEncoding = BAD_OPT[k][5];
            load_ctr(32'h0000_0005);
            exec({OPC_COND_JUMP, BAD_OPT[k][4:0], 5'h00, 14'h0010, 2'b01}, 32'h0000_1000, 32'h0000_0000);
            check(stat, 32'h0000_0001);
            check(loopCounter, 32'h0000_0005);
            check(linkReg, expLink);
        end
        @(negedge clk);
        exec({OPC_COND_JUMP, 5'b10100, 5'h00, 14'h0010, 2'b01}, 32'h0000_1000, 32'h0000_0000);
        expLink = 32'h0000_1004;
        check(stat, 32'h0000_000E);
        check(targetAddr, 32'h0000_1040);
        check(linkReg, expLink);
        strictForms = 1'b0;
    endtask : t_strict

    task automatic t_chain();
        load_ctr(32'h0000_0004);
        @(negedge clk);
        counterLoad      = 1'b1;
        counterLoadValue = 32'h0000_0009;
        exec({OPC_COND_JUMP, 5'b10000, 5'h00, 14'h0004, 2'b00}, 32'h0000_2000, 32'h0000_0000);
        counterLoad      = 1'b0;
        check(loopCounter, 32'h0000_0003);
        check(stat, 32'h0000_000C);
        // back to back: counter test then an unconditional jump
        @(negedge clk);
        instrWord  = {OPC_COND_JUMP, 5'b10010, 5'h00, 14'h0008, 2'b01};
        instrAddr  = 32'h0000_3000;
        instrValid = 1'b1;
        @(negedge clk);
        instrWord  = {OPC_JUMP, 24'h00_0010, 2'b00};
        instrAddr  = 32'h0000_3004;
        check(loopCounter, 32'h0000_0002);
        check(stat, 32'h0000_000A);
        check(linkReg, 32'h0000_3004);
        @(negedge clk);
        instrValid = 1'b0;
        check(stat, 32'h0000_000C);
        check(targetAddr, 32'h0000_3044);
        @(negedge clk);
        check(nextFetch, 32'h0000_3044);
    endtask : t_chain

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (12) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        expLink = 32'h0000_0000;
        check(stat, 32'h0000_0000);
        check(loopCounter, 32'h0000_0000);
        t_uncond();
        t_options(1'b0);
        t_options(1'b1);
        t_strict();
        t_chain();
        print_verdict();
    end
endmodule : tb
